// file: core/dcc_pkg.sv
// package: register map, field layout and carrier types of the dual comparator control
package dcc_pkg;
	// ==========================================
	// register offsets
	localparam logic [7:0] OFS_MASKED_IRQ = 8'h00;
	localparam logic [7:0] OFS_RAW_IRQ = 8'h04;
	localparam logic [7:0] OFS_IRQ_ENABLE = 8'h08;
	localparam logic [7:0] OFS_IRQ_CLEAR = 8'h0C;
	localparam logic [7:0] OFS_REF_CTL = 8'h10;
	localparam logic [7:0] OFS_CMP0_STATUS = 8'h20;
	localparam logic [7:0] OFS_CMP0_CTL = 8'h24;
	localparam logic [7:0] OFS_CMP1_STATUS = 8'h40;
	localparam logic [7:0] OFS_CMP1_CTL = 8'h44;
	// ==========================================
	// field positions
	localparam int REF_POWER_BIT = 9;
	localparam int REF_RANGE_BIT = 8;
	localparam int REF_TAP_LSB = 0;
	localparam int REF_TAP_W = 4;
	localparam int STAT_OUT_BIT = 1;
	localparam int CTL_SRC_LSB = 9;
	localparam int CTL_SRC_W = 2;
	localparam int CTL_LEVEL_BIT = 4;
	localparam int CTL_SENSE_LSB = 2;
	localparam int CTL_SENSE_W = 2;
	localparam int CTL_INVERT_BIT = 1;
	// ==========================================
	// reset values and ladder figures
	localparam logic [31:0] REG_RESET = 32'h0000_0000;
	localparam logic [4:0] LADDER_LOW_OFFSET = 5'h08;
	localparam logic [5:0] LADDER_TOTAL_LOW = 6'h20;
	localparam logic [5:0] LADDER_TOTAL_HIGH = 6'h18;
	localparam int NUM_CMP = 2;
	// ==========================================
	// enumerations
	typedef enum logic [1:0] {
		SRC_OWN_PIN = 2'b00,
		SRC_FIRST_PIN = 2'b01,
		SRC_INTERNAL_REF = 2'b10,
		SRC_RESERVED = 2'b11
	} dcc_src_e;
	typedef enum logic [1:0] {
		SENSE_LEVEL = 2'b00,
		SENSE_FALL = 2'b01,
		SENSE_RISE = 2'b10,
		SENSE_BOTH = 2'b11
	} dcc_sense_e;
	typedef enum logic [1:0] {
		POS_NONE = 2'b00,
		POS_FIRST_PIN = 2'b01,
		POS_INTERNAL_REF = 2'b10,
		POS_OFF = 2'b11
	} dcc_pos_e;
	// ==========================================
	// carriers
	typedef struct packed {
		logic power;
		logic range;
		logic [3:0] tap;
	} dcc_ref_s;
	typedef struct packed {
		dcc_src_e src;
		logic level;
		dcc_sense_e sense;
		logic invert;
	} dcc_ctl_s;
	typedef struct packed {
		dcc_pos_e pos0;
		dcc_pos_e pos1;
		logic shared_is_output;
		logic ref_enable;
		logic [5:0] ref_num;
		logic [5:0] ref_den;
	} dcc_analog_s;
endpackage : dcc_pkg

// file: core/dcc_irq_sense.sv
// one comparator's output sampler and interrupt event detector
`timescale 1ns/10ps
`default_nettype none
module dcc_irq_sense
	import dcc_pkg::*;
(
	input wire logic core_clk,
	input wire logic rst,
	input wire logic raw_in,
	input var dcc_ctl_s ctl,
	output logic value,
	output logic event_pulse
);
	typedef struct packed {
		logic [2:0] sync;
		logic [2:0] settle;
		logic value;
		logic event_pulse;
	} dcc_sense_s;

	dcc_sense_s state;
	dcc_sense_s next_state;
	logic agreed;
	logic level;
	logic primed;

	always_comb begin
		next_state = state;
		next_state.sync = {state.sync[1:0], raw_in};
		// no events until the synchroniser and value flop hold real samples
		primed = (state.settle == 3'h4);
		next_state.settle = primed ? state.settle : state.settle + 3'h1;
		// value changes once the second and third stages agree
		agreed = (state.sync[1] == state.sync[2]) ? state.sync[2] : state.value;
		level = agreed ^ ctl.invert;
		next_state.value = agreed;
		case (ctl.sense)
			SENSE_LEVEL: next_state.event_pulse = (level == ctl.level);
			SENSE_FALL: next_state.event_pulse = state.value & ~agreed;
			SENSE_RISE: next_state.event_pulse = ~state.value & agreed;
			SENSE_BOTH: next_state.event_pulse = state.value ^ agreed;
			default: next_state.event_pulse = 1'b0;
		endcase
		if (!primed) begin
			next_state.event_pulse = 1'b0;
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			state <= '0;
		end else begin
			state <= next_state;
		end
	end

	assign value = state.value;
	assign event_pulse = state.event_pulse;
endmodule : dcc_irq_sense
`default_nettype wire

// file: core/dcc_top.sv
// dual comparator control: apb registers, source routing, ladder code, interrupts
//
// Implementation choice: the APB register port.
`timescale 1ns/10ps
`default_nettype none
// How it works
// - negative inputs come from pins; positive input picks pin, first pin or ladder.
// - comparator zero codes 00/01 own pin, 10 ladder, 11 reserved; drives shared pin.
// - comparator one negative is shared pin; 00 none, 01 first pin, 10 ladder.
// - shared pin is either comparator zero output or comparator one input, never both.
// - every source mode lets the output raise an interrupt; pin output where present.
// - ladder unpowered gives ground reference regardless of range and tap.
// - powered, range clear: ladder of 32 units, reference ratio (tap+8)/32.
// - powered, range set: ladder of 24 units, reference ratio tap/24.
// - registers decode at offsets from the base and all reset to zero.
// - raw status holds one sticky bit per comparator, bit 0 and bit 1.
// - enable register bits 0 and 1 let each comparator raise the interrupt.
// - masked status shows masked state of comparators in bits 0 and 1.
// - unused bits read an undefined value, here zero; software leaves them alone.
// - reference control: power bit 9, range bit 8, tap bits 3 to 0.
// - each comparator status reports its current output in bit 1.
// - level sense raises on low output when polarity bit is 0, else high.
module dcc_top
	import dcc_pkg::*;
(
	input wire logic core_clk,
	input wire logic rst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [1:0] comparator_output,
	output logic shared_output_or_negative_pin_o,
	output logic shared_output_or_negative_pin_oe_n,
	output var dcc_analog_s analog_ctl,
	output logic irq
);
	// ==========================================
	// state
	typedef struct packed {
		logic [1:0] raw_irq;
		logic [1:0] irq_enable;
		dcc_ref_s ref_ctl;
		dcc_ctl_s ctl0;
		dcc_ctl_s ctl1;
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
		logic pin_o;
		logic pin_oe_n;
		dcc_analog_s analog;
		logic irq;
	} dcc_state_s;

	dcc_state_s state;
	dcc_state_s next_state;
	logic [1:0] cmp_value;
	logic [1:0] cmp_event;
	logic [1:0] masked;
	logic setup;
	logic wr;
	logic [1:0] clr;

	// ==========================================
	// register field packing
	function automatic logic [31:0] pack_ctl(input dcc_ctl_s c);
		logic [31:0] w;
		w = REG_RESET;
		w[CTL_SRC_LSB +: CTL_SRC_W] = c.src;
		w[CTL_LEVEL_BIT] = c.level;
		w[CTL_SENSE_LSB +: CTL_SENSE_W] = c.sense;
		w[CTL_INVERT_BIT] = c.invert;
		return w;
	endfunction : pack_ctl

	function automatic dcc_ctl_s unpack_ctl(input logic [31:0] w);
		dcc_ctl_s c;
		c.src = dcc_src_e'(w[CTL_SRC_LSB +: CTL_SRC_W]);
		c.level = w[CTL_LEVEL_BIT];
		c.sense = dcc_sense_e'(w[CTL_SENSE_LSB +: CTL_SENSE_W]);
		c.invert = w[CTL_INVERT_BIT];
		return c;
	endfunction : unpack_ctl

	// ==========================================
	// comparator samplers
	for (genvar i = 0; i < NUM_CMP; i++) begin : g_sense
		dcc_irq_sense u_sense (
			.core_clk(core_clk),
			.rst(rst),
			.raw_in(comparator_output[i]),
			.ctl((i == 0) ? state.ctl0 : state.ctl1),
			.value(cmp_value[i]),
			.event_pulse(cmp_event[i])
		);
	end

	// ==========================================
	// next state
	always_comb begin
		next_state = state;
		setup = psel & ~penable;
		wr = setup & pwrite & pstrb[0];
		clr = 2'b00;
		masked = state.raw_irq & state.irq_enable;
		next_state.pready = setup;
		next_state.pslverr = 1'b0;
		if (setup) begin
			next_state.prdata = REG_RESET;
			case (paddr[7:0])
				OFS_MASKED_IRQ: next_state.prdata[1:0] = masked;
				OFS_RAW_IRQ: next_state.prdata[1:0] = state.raw_irq;
				OFS_IRQ_ENABLE: next_state.prdata[1:0] = state.irq_enable;
				OFS_IRQ_CLEAR: next_state.prdata = REG_RESET;
				OFS_REF_CTL: begin
					next_state.prdata[REF_POWER_BIT] = state.ref_ctl.power;
					next_state.prdata[REF_RANGE_BIT] = state.ref_ctl.range;
					next_state.prdata[REF_TAP_LSB +: REF_TAP_W] = state.ref_ctl.tap;
				end
				OFS_CMP0_STATUS: next_state.prdata[STAT_OUT_BIT] = cmp_value[0];
				OFS_CMP0_CTL: next_state.prdata = pack_ctl(state.ctl0);
				OFS_CMP1_STATUS: next_state.prdata[STAT_OUT_BIT] = cmp_value[1];
				OFS_CMP1_CTL: next_state.prdata = pack_ctl(state.ctl1);
				default: next_state.pslverr = 1'b1;
			endcase
			if (paddr[11:8] != 4'h0) begin
				next_state.pslverr = 1'b1;
			end
		end
		if (wr && paddr[11:8] == 4'h0) begin
			case (paddr[7:0])
				OFS_IRQ_ENABLE: next_state.irq_enable = pwdata[1:0];
				OFS_IRQ_CLEAR: clr = pwdata[1:0];
				OFS_REF_CTL: begin
					next_state.ref_ctl.power = pwdata[REF_POWER_BIT];
					next_state.ref_ctl.range = pstrb[1] ? pwdata[REF_RANGE_BIT] : state.ref_ctl.range;
					next_state.ref_ctl.tap = pwdata[REF_TAP_LSB +: REF_TAP_W];
				end
				OFS_CMP0_CTL: next_state.ctl0 = unpack_ctl(pwdata);
				OFS_CMP1_CTL: next_state.ctl1 = unpack_ctl(pwdata);
				default: next_state.irq_enable = state.irq_enable;
			endcase
		end
		// set wins over clear; every source mode keeps interrupts live
		next_state.raw_irq = (state.raw_irq & ~clr) | cmp_event;
		next_state.irq = |((next_state.raw_irq) & next_state.irq_enable);
		// positive source routing
		case (state.ctl0.src)
			SRC_OWN_PIN, SRC_FIRST_PIN: next_state.analog.pos0 = POS_FIRST_PIN;
			SRC_INTERNAL_REF: next_state.analog.pos0 = POS_INTERNAL_REF;
			default: next_state.analog.pos0 = POS_OFF;
		endcase
		case (state.ctl1.src)
			SRC_OWN_PIN: next_state.analog.pos1 = POS_NONE;
			SRC_FIRST_PIN: next_state.analog.pos1 = POS_FIRST_PIN;
			SRC_INTERNAL_REF: next_state.analog.pos1 = POS_INTERNAL_REF;
			default: next_state.analog.pos1 = POS_OFF;
		endcase
		// shared pin is comparator zero output unless comparator one's interrupt enable bit is set
		next_state.analog.shared_is_output = ~state.irq_enable[1];
		next_state.pin_oe_n = ~next_state.analog.shared_is_output;
		next_state.pin_o = next_state.analog.shared_is_output & cmp_value[0];
		// ladder ratio numerator / denominator
		next_state.analog.ref_enable = state.ref_ctl.power;
		if (!state.ref_ctl.power) begin
			next_state.analog.ref_num = 6'h00;
			next_state.analog.ref_den = LADDER_TOTAL_LOW;
		end else if (!state.ref_ctl.range) begin
			next_state.analog.ref_num = {2'b00, state.ref_ctl.tap} + {1'b0, LADDER_LOW_OFFSET};
			next_state.analog.ref_den = LADDER_TOTAL_LOW;
		end else begin
			next_state.analog.ref_num = {2'b00, state.ref_ctl.tap};
			next_state.analog.ref_den = LADDER_TOTAL_HIGH;
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			state <= '0;
			state.analog.ref_den <= LADDER_TOTAL_LOW;
			state.analog.shared_is_output <= 1'b1;
			state.analog.pos0 <= POS_FIRST_PIN;
			state.pin_oe_n <= 1'b0;
		end else begin
			state <= next_state;
		end
	end

	// ==========================================
	// outputs
	assign prdata = state.prdata;
	assign pready = state.pready;
	assign pslverr = state.pslverr;
	assign shared_output_or_negative_pin_o = state.pin_o;
	assign shared_output_or_negative_pin_oe_n = state.pin_oe_n;
	assign analog_ctl = state.analog;
	assign irq = state.irq;
endmodule : dcc_top
`default_nettype wire

// file: verification/dcc_top_sva.sv
// checker: bus, ladder, pin and interrupt relations of the comparator block
`timescale 1ns/10ps
`default_nettype none
module dcc_top_sva
	import dcc_pkg::*;
(
	input wire logic core_clk,
	input wire logic rst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic [1:0] comparator_output,
	input wire logic shared_output_or_negative_pin_o,
	input wire logic shared_output_or_negative_pin_oe_n,
	input var dcc_analog_s analog_ctl,
	input wire logic irq
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (rst);
	a_ready_after_setup: assert property (psel && !penable |=> pready)
		else $error("no ready after setup");
	a_unmapped_error: assert property (psel && !penable && paddr == 12'h030 |=> pslverr)
		else $error("unmapped access without error");
	a_ref_off_ground: assert property (!analog_ctl.ref_enable |-> analog_ctl.ref_num == 6'h00)
		else $error("unpowered ladder not ground");
	a_ladder_low: assert property (analog_ctl.ref_enable && analog_ctl.ref_den == 6'h20
		|-> analog_ctl.ref_num >= 6'h08 && analog_ctl.ref_num <= 6'h17)
		else $error("low range ratio out of span");
	a_ladder_high: assert property (analog_ctl.ref_enable && analog_ctl.ref_den != 6'h20
		|-> analog_ctl.ref_den == 6'h18 && analog_ctl.ref_num <= 6'h0F)
		else $error("high range ratio wrong");
	a_irq_masked_off: assert property (psel && !penable && pwrite && pstrb[0]
		&& paddr == 12'h008 && pwdata[1:0] == 2'b00 |-> ##3 !irq)
		else $error("irq high with all enables clear");
	a_pin_one_role: assert property (shared_output_or_negative_pin_oe_n != analog_ctl.shared_is_output)
		else $error("shared pin role mismatch");
	a_pin_follows: assert property (!shared_output_or_negative_pin_oe_n && $rose(comparator_output[0])
		|-> ##[2:8] shared_output_or_negative_pin_o)
		else $error("pin does not follow comparator zero");
endmodule : dcc_top_sva
bind dcc_top dcc_top_sva dcc_top_sva_i (.*);
`default_nettype wire

// file: verification/dcc_cmp_model.sv
// comparator cell model: outputs follow commanded levels, promptly or late
`timescale 1ns/10ps
`default_nettype none
module dcc_cmp_model
	import dcc_pkg::*;
(
	input wire logic core_clk,
	input wire logic [1:0] level,
	input wire logic slow,
	output logic [1:0] comparator_output
);
	logic [1:0] d1;
	logic [1:0] d2;
	always @(posedge core_clk) begin
		d1 <= level;
		d2 <= d1;
		// full-scale logic levels only, so pin schmitt triggers may stay on
		comparator_output <= slow ? d2 : level;
	end
endmodule : dcc_cmp_model
`default_nettype wire

// file: verification/testbench.sv
// testbench: register, ladder, routing and interrupt scenarios
`timescale 1ns/10ps
`default_nettype none
module testbench
	import dcc_pkg::*;
;
	logic core_clk, rst, psel, penable, pwrite, pready, pslverr, pin_o, oe_n, irq, slow, err;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rdat;
	logic [1:0] comparator_output, level;
	dcc_analog_s analog_ctl;
	int n_mismatch = 0;
	int checks = 0;
	dcc_top dcc_top_i (.core_clk(core_clk), .rst(rst), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hF), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .comparator_output(comparator_output),
		.shared_output_or_negative_pin_o(pin_o), .shared_output_or_negative_pin_oe_n(oe_n),
		.analog_ctl(analog_ctl), .irq(irq));
	dcc_cmp_model dcc_cmp_model_i (.core_clk(core_clk), .level(level), .slow(slow),
		.comparator_output(comparator_output));
	// ==========================================
	// shared tasks
	task automatic conclude;
		$display("checks %0d mismatches %0d", checks, n_mismatch);
		if (n_mismatch == 0 && checks > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask : conclude
	task automatic chk(input string s, input logic [31:0] x, input logic [31:0] g);
		checks++;
		if (g !== x) begin
			$display("ERROR %s expected %h seen %h", s, x, g);
			n_mismatch++;
		end
	endtask : chk
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge core_clk);
		penable <= 1'b1;
		for (n = 0; n < 20; n++) begin
			@(negedge core_clk);
			if (pready === 1'b1) break;
		end
		rdat = prdata;
		err = pslverr;
		@(posedge core_clk);
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge core_clk);
		chk("bus answer", 1'b1, n < 20);
		if (n >= 20) conclude();
	endtask : apb
	task automatic rd(input logic [11:0] a, input logic [31:0] x);
		apb(1'b0, a, 32'h0000_0000);
		chk($sformatf("reg %h", a), x, rdat);
	endtask : rd
	task automatic wait_irq(input logic x);
		for (int n = 0; n < 40 && irq !== x; n++) @(negedge core_clk);
		chk("irq", x, irq);
		if (irq !== x) conclude();
	endtask : wait_irq
	// ==========================================
	// scenarios
	task automatic s_reset;
		logic [7:0] ofs [8] = '{8'h04, 8'h00, 8'h08, 8'h10, 8'h20, 8'h24, 8'h40, 8'h44};
		for (int i = 0; i < 8; i++) begin
			rd({4'h0, ofs[i]}, (ofs[i][5] || ofs[i][6]) && !ofs[i][2] ? 2 : 0);
		end
		apb(1'b0, 12'h030, 32'h0000_0000);
		chk("unmapped error", 1'b1, err);
		apb(1'b1, 12'h000, 32'h0000_0003);
		rd(12'h000, 32'h0000_0000);
		apb(1'b1, 12'h00C, 32'h0000_0003);
	endtask : s_reset
	task automatic s_ref;
		logic [31:0] cfg [3] = '{32'h0000_030F, 32'h0000_0205, 32'h0000_010F};
		logic [6:0] en_num [3] = '{7'h4F, 7'h4D, 7'h00};
		logic [5:0] den [2] = '{6'h18, 6'h20};
		for (int i = 0; i < 3; i++) begin
			apb(1'b1, 12'h010, cfg[i] | 32'hFFFF_FC00);
			rd(12'h010, cfg[i]);
			chk("ladder", en_num[i], {analog_ctl.ref_enable, analog_ctl.ref_num});
			if (i < 2) chk("ladder den", den[i], analog_ctl.ref_den);
		end
	endtask : s_ref
	task automatic s_src;
		logic [7:0] e0 = 8'hE5;
		logic [7:0] e1 = 8'hE4;
		for (int i = 0; i < 4; i++) begin
			apb(1'b1, 12'h024, {21'h0, i[1:0], 9'h008});
			apb(1'b1, 12'h044, {21'h0, i[1:0], 9'h008});
			chk("source zero", e0[2*i+:2], analog_ctl.pos0);
			chk("source one", e1[2*i+:2], analog_ctl.pos1);
		end
	endtask : s_src
	task automatic s_irq;
		slow <= 1'b1;
		level <= 2'b10;
		apb(1'b1, 12'h008, 32'h0000_0001);
		repeat (8) @(posedge core_clk);
		level <= 2'b11;
		wait_irq(1'b1);
		rd(12'h004, 32'h0000_0001);
		rd(12'h000, 32'h0000_0001);
		rd(12'h020, 32'h0000_0002);
		apb(1'b1, 12'h008, 32'h0000_0000);
		wait_irq(1'b0);
		rd(12'h004, 32'h0000_0001);
		apb(1'b1, 12'h00C, 32'h0000_0001);
		rd(12'h004, 32'h0000_0000);
	endtask : s_irq
	task automatic s_level;
		slow <= 1'b0;
		apb(1'b1, 12'h044, 32'h0000_0000);
		apb(1'b1, 12'h008, 32'h0000_0002);
		level <= 2'b01;
		wait_irq(1'b1);
		chk("pin role", 1'b1, oe_n);
		rd(12'h000, 32'h0000_0002);
		apb(1'b1, 12'h044, 32'h0000_0010);
		apb(1'b1, 12'h00C, 32'h0000_0002);
		wait_irq(1'b0);
		level <= 2'b11;
		wait_irq(1'b1);
		apb(1'b1, 12'h008, 32'h0000_0000);
		repeat (8) @(posedge core_clk);
		chk("pin out", 1'b1, pin_o);
		level <= 2'b10;
		repeat (8) @(posedge core_clk);
		chk("pin out", 1'b0, pin_o);
	endtask : s_level
	// ==========================================
	// clock and main sequence
	initial begin
		core_clk = 1'b0;
		forever #4 core_clk = ~core_clk;
	end
	initial begin
		rst = 1'b1;
		{psel, penable, pwrite, slow} = 4'h0;
		paddr = 12'h000;
		pwdata = 32'h0000_0000;
		level = 2'b11;
		repeat (8) @(posedge core_clk);
		rst <= 1'b0;
		@(posedge core_clk);
		s_reset();
		s_ref();
		s_src();
		s_irq();
		s_level();
		conclude();
	end
endmodule : testbench
`default_nettype wire
